// ===== rtl/usc_cfg.svh
`ifndef USC_CFG_SVH
`define USC_CFG_SVH
// Register addresses
`define USC_ADDR_STACTL 4'h0
`define USC_ADDR_IRQ_STATUS 4'h1
`define USC_ADDR_IRQ_MASK 4'h2
`define USC_ADDR_BAUD 4'h3
// Status and control field positions
`define USC_BIT_TXSEL_HI 15
`define USC_BIT_TXINV 14
`define USC_BIT_TXSEL_LO 13
`define USC_BIT_BRK 11
`define USC_BIT_TXEN 10
`define USC_BIT_TXBF 9
`define USC_BIT_TXEMPTY 8
`define USC_BIT_RXSEL_HI 7
`define USC_BIT_RXSEL_LO 6
`define USC_BIT_ADDRESS_DETECT_ENABLE 5
`define USC_BIT_RX_LINE_IDLE 4
`define USC_BIT_PARITY_ERROR 3
`define USC_BIT_FRAMING_ERROR 2
`define USC_BIT_RX_OVERRUN_ERROR 1
`define USC_BIT_RXDA 0
// Reset values
`define USC_STACTL_RESET 16'h0110
`define USC_BAUD_RESET 16'h001A
// Interrupt status bits
`define USC_IRQ_TX 0
`define USC_IRQ_RX 1
`define USC_IRQ_RX_OVERRUN_ERROR 2
// Buffer geometry and frame
`define USC_BUF_DEPTH 4
`define USC_BRK_ZEROS 4'hC
`define USC_DATA_BITS 4'h8
`endif

// ===== rtl/usc_pkg.sv
package usc_pkg;
   typedef enum logic [1:0] {
      USC_TX_IDLE = 2'b00,
      USC_TX_START = 2'b01,
      USC_TX_DATA = 2'b11,
      USC_TX_STOP = 2'b10
   } usc_tx_state_e;
   typedef logic [7:0] usc_char_t;
   typedef logic [15:0] usc_word_t;
endpackage

// ===== rtl/usc_fifo_mem.sv
`timescale 1ns/1ps
`include "usc_cfg.svh"
// Four-entry character store; read data registered
module usc_fifo_mem (
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [1:0] wr_addr,
   input wire usc_pkg::usc_char_t wr_data,
   input wire logic [1:0] rd_addr,
   output usc_pkg::usc_char_t rd_data
);
   usc_pkg::usc_char_t mem_ff [`USC_BUF_DEPTH];
   usc_pkg::usc_char_t rd_ff;
   // Write port and registered read
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem_ff[wr_addr] <= wr_data;
      end
      // Write-through so a character written this cycle is seen at once
      if (wr_en && (wr_addr == rd_addr)) begin
         rd_ff <= wr_data;
      end else begin
         rd_ff <= mem_ff[rd_addr];
      end
   end
   assign rd_data = rd_ff;
endmodule // usc_fifo_mem

// ===== rtl/usc_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a pin level
module usc_sync (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta_ff;
   logic sync_ff;
   // Reset high: idle line level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end
   assign dout = sync_ff;
endmodule // usc_sync

// ===== rtl/usc_uart_status_control.sv
// Behaviour
// - The two-bit transmit interrupt select field sits at bits 15 (upper) and 13 (lower).
// - With transmit select 10 the interrupt fires when a load into the shifter empties the buffer.
// - With transmit select 01 the interrupt fires when the last character has fully shifted out.
// - With transmit select 00 the interrupt fires on every load into the shifter.
// - The idle inversion bit gives idle low when set without infrared, and is reversed with infrared.
// - A break request sends start, twelve zeros and stop on the next transmission, then clears itself.
// - With transmit enable set the serial logic drives the transmit pin.
// - Clearing transmit enable aborts sending, empties the buffer and returns the pin to port output.
// - The read-only buffer full flag is one when no transmit slot is free.
// - The read-only idle flag is one only when shifter and buffer are both empty.
// - With receive select 11 the interrupt fires when a transfer makes the buffer hold four characters.
// - With receive select 10 the interrupt fires when a transfer makes the buffer hold three characters.
// - With receive select 0x the interrupt fires on every received character that is transferred into the buffer.
// - Bit 12 ignores writes and reads zero.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "usc_cfg.svh"
module usc_uart_status_control (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [7:0] tx_data,
   input wire logic tx_data_valid,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char,
   input wire logic rx_parity_error,
   input wire logic rx_framing_error,
   input wire logic rx_line_idle_in,
   input wire logic rx_pop,
   output logic [7:0] rx_data,
   input wire logic infrared_encode_enable,
   input wire logic port_latch_out,
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   output logic irq
);
   //---------------------------------------------------------
   // Registers
   //---------------------------------------------------------
   logic [1:0] tx_irq_select_ff, nxt_tx_irq_select;
   logic tx_idle_invert_ff, nxt_tx_idle_invert;
   logic tx_break_request_ff, nxt_tx_break_request;
   logic tx_enable_ff, nxt_tx_enable;
   logic [1:0] rx_irq_select_ff, nxt_rx_irq_select;
   logic address_detect_enable_ff, nxt_address_detect_enable;
   logic rx_overrun_error_ff, nxt_rx_overrun_error;
   logic parity_error_ff, nxt_parity_error;
   logic framing_error_ff, nxt_framing_error;
   logic [2:0] irq_status_ff, nxt_irq_status;
   logic [2:0] irq_mask_ff, nxt_irq_mask;
   logic [15:0] baud_ff, nxt_baud;
   logic [15:0] rdata_ff, nxt_rdata;
   // Transmit buffer
   logic [1:0] tx_wp_ff, nxt_tx_wp, tx_rp_ff, nxt_tx_rp;
   logic [2:0] tx_cnt_ff, nxt_tx_cnt;
   // Transmitter
   usc_pkg::usc_tx_state_e tx_state_ff, nxt_tx_state;
   logic [7:0] tx_shift_ff, nxt_tx_shift;
   logic [3:0] tx_bits_ff, nxt_tx_bits;
   logic [15:0] tx_baud_cnt_ff, nxt_tx_baud_cnt;
   logic tx_is_break_ff, nxt_tx_is_break;
   logic tx_line_ff, nxt_tx_line;
   logic tx_load_pend_ff, nxt_tx_load_pend;
   // Receive buffer
   logic [1:0] rx_wp_ff, nxt_rx_wp, rx_rp_ff, nxt_rx_rp;
   logic [2:0] rx_cnt_ff, nxt_rx_cnt;
   logic rx_idle_sync;
   logic rx_pin_sync;
   usc_pkg::usc_char_t tx_head;
   logic tx_push, tx_load, tx_done, rx_push, rx_take, rd_sta, wr_sta;
   logic ev_tx, ev_rx, tx_full;
   logic idle_level;
   //---------------------------------------------------------
   // Storage and synchronisers
   //---------------------------------------------------------
   usc_fifo_mem u_tx_mem (
      .sys_clk(sys_clk),
      .wr_en(tx_push),
      .wr_addr(tx_wp_ff),
      .wr_data(tx_data),
      .rd_addr(nxt_tx_rp),
      .rd_data(tx_head)
   );
   usc_fifo_mem u_rx_mem (
      .sys_clk(sys_clk),
      .wr_en(rx_push),
      .wr_addr(rx_wp_ff),
      .wr_data(rx_char),
      .rd_addr(nxt_rx_rp),
      .rd_data(rx_data)
   );
   usc_sync u_sync_idle (
      .sys_clk(sys_clk),
      .rst(rst),
      .din(rx_line_idle_in),
      .dout(rx_idle_sync)
   );
   // Received line level is synchronised into rx_pin_sync, which no logic reads
   usc_sync u_sync_rx (
      .sys_clk(sys_clk),
      .rst(rst),
      .din(serial_rx_pin),
      .dout(rx_pin_sync)
   );
   //---------------------------------------------------------
   // Strobes
   //---------------------------------------------------------
   // Bus decode and buffer events
   always_comb begin
      wr_sta = reg_wr && (reg_addr == `USC_ADDR_STACTL);
      rd_sta = reg_rd && (reg_addr == `USC_ADDR_IRQ_STATUS);
      tx_full = (tx_cnt_ff == 3'(`USC_BUF_DEPTH));
      tx_push = tx_data_valid && tx_enable_ff && !tx_full;
      tx_load = tx_load_pend_ff;
      rx_push = rx_char_valid && (rx_cnt_ff != 3'(`USC_BUF_DEPTH));
      rx_take = rx_pop && (rx_cnt_ff != 3'h0);
      tx_done = (tx_state_ff == usc_pkg::USC_TX_STOP) && (tx_baud_cnt_ff == 16'h0000);
   end
   //---------------------------------------------------------
   // Control register and interrupt logic
   //---------------------------------------------------------
   always_comb begin
      nxt_tx_irq_select = tx_irq_select_ff;
      nxt_tx_idle_invert = tx_idle_invert_ff;
      nxt_tx_break_request = tx_break_request_ff;
      nxt_tx_enable = tx_enable_ff;
      nxt_rx_irq_select = rx_irq_select_ff;
      nxt_address_detect_enable = address_detect_enable_ff;
      nxt_rx_overrun_error = rx_overrun_error_ff;
      nxt_parity_error = parity_error_ff;
      nxt_framing_error = framing_error_ff;
      nxt_irq_mask = irq_mask_ff;
      nxt_baud = baud_ff;
      nxt_irq_status = irq_status_ff;
      if (wr_sta) begin
         // split select field; bit 12 not stored
         nxt_tx_irq_select = {reg_wdata[`USC_BIT_TXSEL_HI], reg_wdata[`USC_BIT_TXSEL_LO]};
         nxt_tx_idle_invert = reg_wdata[`USC_BIT_TXINV];
         nxt_tx_break_request = reg_wdata[`USC_BIT_BRK];
         nxt_tx_enable = reg_wdata[`USC_BIT_TXEN];
         nxt_rx_irq_select = {reg_wdata[`USC_BIT_RXSEL_HI], reg_wdata[`USC_BIT_RXSEL_LO]};
         nxt_address_detect_enable = reg_wdata[`USC_BIT_ADDRESS_DETECT_ENABLE];
         if (!reg_wdata[`USC_BIT_RX_OVERRUN_ERROR]) begin
            nxt_rx_overrun_error = 1'b0;
         end
      end
      if (reg_wr && (reg_addr == `USC_ADDR_IRQ_MASK)) begin
         nxt_irq_mask = reg_wdata[2:0];
      end
      if (reg_wr && (reg_addr == `USC_ADDR_BAUD)) begin
         nxt_baud = reg_wdata;
      end
      // break request clears when the break frame ends
      if (tx_done && tx_is_break_ff) begin
         nxt_tx_break_request = 1'b0;
      end
      if (rx_char_valid && !rx_push) begin
         nxt_rx_overrun_error = 1'b1;
      end
      if (rx_push) begin
         nxt_parity_error = rx_parity_error;
         nxt_framing_error = rx_framing_error;
      end
      // Transmit interrupt selection
      case (tx_irq_select_ff)
         2'b00: ev_tx = tx_load;
         2'b01: ev_tx = tx_done && (tx_cnt_ff == 3'h0) && !tx_load_pend_ff;
         2'b10: ev_tx = tx_load && (tx_cnt_ff == 3'h0);
         default: ev_tx = 1'b0;
      endcase
      // Receive interrupt selection
      case (rx_irq_select_ff)
         2'b11: ev_rx = rx_push && !rx_take && (rx_cnt_ff == 3'h3);
         2'b10: ev_rx = rx_push && !rx_take && (rx_cnt_ff == 3'h2);
         default: ev_rx = rx_push;
      endcase
      // Sticky status, read clears, new events win
      if (rd_sta) begin
         nxt_irq_status = 3'h0;
      end
      nxt_irq_status[`USC_IRQ_TX] = nxt_irq_status[`USC_IRQ_TX] | ev_tx;
      nxt_irq_status[`USC_IRQ_RX] = nxt_irq_status[`USC_IRQ_RX] | ev_rx;
      nxt_irq_status[`USC_IRQ_RX_OVERRUN_ERROR] = nxt_irq_status[`USC_IRQ_RX_OVERRUN_ERROR] | (rx_char_valid && !rx_push);
   end
   //---------------------------------------------------------
   // Buffers and transmitter
   //---------------------------------------------------------
   always_comb begin
      nxt_tx_wp = tx_wp_ff;
      nxt_tx_rp = tx_rp_ff;
      nxt_tx_cnt = tx_cnt_ff;
      nxt_tx_state = tx_state_ff;
      nxt_tx_shift = tx_shift_ff;
      nxt_tx_bits = tx_bits_ff;
      nxt_tx_baud_cnt = tx_baud_cnt_ff;
      nxt_tx_is_break = tx_is_break_ff;
      nxt_tx_load_pend = 1'b0;
      nxt_rx_wp = rx_wp_ff;
      nxt_rx_rp = rx_rp_ff;
      nxt_rx_cnt = rx_cnt_ff;
      // idle level by inversion and infrared mode
      idle_level = tx_idle_invert_ff ~^ infrared_encode_enable;
      nxt_tx_line = idle_level;
      if (tx_push) begin
         nxt_tx_wp = tx_wp_ff + 2'h1;
      end
      case (tx_state_ff)
         usc_pkg::USC_TX_IDLE: begin
            if (tx_enable_ff && (tx_cnt_ff != 3'h0 || tx_break_request_ff)) begin
               nxt_tx_state = usc_pkg::USC_TX_START;
               nxt_tx_baud_cnt = baud_ff;
               nxt_tx_is_break = tx_break_request_ff;
               nxt_tx_bits = tx_break_request_ff ? `USC_BRK_ZEROS : `USC_DATA_BITS;
               nxt_tx_shift = tx_break_request_ff ? 8'h00 : tx_head;
               if (!tx_break_request_ff) begin
                  nxt_tx_rp = tx_rp_ff + 2'h1;
                  nxt_tx_load_pend = 1'b1;
               end
            end
         end
         usc_pkg::USC_TX_START: begin
            nxt_tx_line = ~idle_level;
            if (tx_baud_cnt_ff == 16'h0000) begin
               nxt_tx_baud_cnt = baud_ff;
               nxt_tx_state = usc_pkg::USC_TX_DATA;
            end else begin
               nxt_tx_baud_cnt = tx_baud_cnt_ff - 16'h0001;
            end
         end
         usc_pkg::USC_TX_DATA: begin
            // break drives twelve zero bit times
            nxt_tx_line = tx_is_break_ff ? ~idle_level : (tx_shift_ff[0] ~^ idle_level);
            if (tx_baud_cnt_ff == 16'h0000) begin
               nxt_tx_baud_cnt = baud_ff;
               nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
               nxt_tx_bits = tx_bits_ff - 4'h1;
               if (tx_bits_ff == 4'h1) begin
                  nxt_tx_state = usc_pkg::USC_TX_STOP;
               end
            end else begin
               nxt_tx_baud_cnt = tx_baud_cnt_ff - 16'h0001;
            end
         end
         usc_pkg::USC_TX_STOP: begin
            if (tx_baud_cnt_ff == 16'h0000) begin
               nxt_tx_state = usc_pkg::USC_TX_IDLE;
            end else begin
               nxt_tx_baud_cnt = tx_baud_cnt_ff - 16'h0001;
            end
         end
         default: nxt_tx_state = usc_pkg::USC_TX_IDLE;
      endcase
      nxt_tx_cnt = tx_cnt_ff + 3'(tx_push) - 3'(nxt_tx_load_pend);
      // disable aborts and resets the buffer
      if (!tx_enable_ff) begin
         nxt_tx_state = usc_pkg::USC_TX_IDLE;
         nxt_tx_wp = 2'h0;
         nxt_tx_rp = 2'h0;
         nxt_tx_cnt = 3'h0;
         nxt_tx_load_pend = 1'b0;
      end
      if (rx_push) begin
         nxt_rx_wp = rx_wp_ff + 2'h1;
      end
      if (rx_take) begin
         nxt_rx_rp = rx_rp_ff + 2'h1;
      end
      nxt_rx_cnt = rx_cnt_ff + 3'(rx_push) - 3'(rx_take);
   end
   //---------------------------------------------------------
   // Read mux
   //---------------------------------------------------------
   always_comb begin
      nxt_rdata = 16'h0000;
      case (reg_addr)
         `USC_ADDR_STACTL: begin
            nxt_rdata[`USC_BIT_TXSEL_HI] = tx_irq_select_ff[1];
            nxt_rdata[`USC_BIT_TXINV] = tx_idle_invert_ff;
            nxt_rdata[`USC_BIT_TXSEL_LO] = tx_irq_select_ff[0];
            nxt_rdata[`USC_BIT_BRK] = tx_break_request_ff;
            nxt_rdata[`USC_BIT_TXEN] = tx_enable_ff;
            nxt_rdata[`USC_BIT_TXBF] = tx_full;
            // idle only when shifter and buffer empty
            nxt_rdata[`USC_BIT_TXEMPTY] = (tx_state_ff == usc_pkg::USC_TX_IDLE) && (tx_cnt_ff == 3'h0);
            nxt_rdata[`USC_BIT_RXSEL_HI] = rx_irq_select_ff[1];
            nxt_rdata[`USC_BIT_RXSEL_LO] = rx_irq_select_ff[0];
            nxt_rdata[`USC_BIT_ADDRESS_DETECT_ENABLE] = address_detect_enable_ff;
            nxt_rdata[`USC_BIT_RX_LINE_IDLE] = rx_idle_sync;
            nxt_rdata[`USC_BIT_PARITY_ERROR] = parity_error_ff;
            nxt_rdata[`USC_BIT_FRAMING_ERROR] = framing_error_ff;
            nxt_rdata[`USC_BIT_RX_OVERRUN_ERROR] = rx_overrun_error_ff;
            nxt_rdata[`USC_BIT_RXDA] = (rx_cnt_ff != 3'h0);
         end
         `USC_ADDR_IRQ_STATUS: nxt_rdata = {13'h0000, irq_status_ff};
         `USC_ADDR_IRQ_MASK: nxt_rdata = {13'h0000, irq_mask_ff};
         `USC_ADDR_BAUD: nxt_rdata = baud_ff;
         default: nxt_rdata = 16'h0000;
      endcase
      if (!reg_rd) begin
         nxt_rdata = 16'h0000;
      end
   end
   //---------------------------------------------------------
   // State registers
   //---------------------------------------------------------
   // reset values
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_irq_select_ff <= 2'h0;
         tx_idle_invert_ff <= 1'b0;
         tx_break_request_ff <= 1'b0;
         tx_enable_ff <= 1'b0;
         rx_irq_select_ff <= 2'h0;
         address_detect_enable_ff <= 1'b0;
         rx_overrun_error_ff <= 1'b0;
         parity_error_ff <= 1'b0;
         framing_error_ff <= 1'b0;
         irq_status_ff <= 3'h0;
         irq_mask_ff <= 3'h0;
         baud_ff <= `USC_BAUD_RESET;
         rdata_ff <= 16'h0000;
         tx_wp_ff <= 2'h0;
         tx_rp_ff <= 2'h0;
         tx_cnt_ff <= 3'h0;
         tx_state_ff <= usc_pkg::USC_TX_IDLE;
         tx_shift_ff <= 8'h00;
         tx_bits_ff <= 4'h0;
         tx_baud_cnt_ff <= 16'h0000;
         tx_is_break_ff <= 1'b0;
         tx_line_ff <= 1'b1;
         tx_load_pend_ff <= 1'b0;
         rx_wp_ff <= 2'h0;
         rx_rp_ff <= 2'h0;
         rx_cnt_ff <= 3'h0;
      end else begin
         tx_irq_select_ff <= nxt_tx_irq_select;
         tx_idle_invert_ff <= nxt_tx_idle_invert;
         tx_break_request_ff <= nxt_tx_break_request;
         tx_enable_ff <= nxt_tx_enable;
         rx_irq_select_ff <= nxt_rx_irq_select;
         address_detect_enable_ff <= nxt_address_detect_enable;
         rx_overrun_error_ff <= nxt_rx_overrun_error;
         parity_error_ff <= nxt_parity_error;
         framing_error_ff <= nxt_framing_error;
         irq_status_ff <= nxt_irq_status;
         irq_mask_ff <= nxt_irq_mask;
         baud_ff <= nxt_baud;
         rdata_ff <= nxt_rdata;
         tx_wp_ff <= nxt_tx_wp;
         tx_rp_ff <= nxt_tx_rp;
         tx_cnt_ff <= nxt_tx_cnt;
         tx_state_ff <= nxt_tx_state;
         tx_shift_ff <= nxt_tx_shift;
         tx_bits_ff <= nxt_tx_bits;
         tx_baud_cnt_ff <= nxt_tx_baud_cnt;
         tx_is_break_ff <= nxt_tx_is_break;
         tx_line_ff <= nxt_tx_line;
         tx_load_pend_ff <= nxt_tx_load_pend;
         rx_wp_ff <= nxt_rx_wp;
         rx_rp_ff <= nxt_rx_rp;
         rx_cnt_ff <= nxt_rx_cnt;
      end
   end
   //---------------------------------------------------------
   // Outputs
   //---------------------------------------------------------
   assign reg_rdata = rdata_ff;
   assign irq = |(irq_status_ff & irq_mask_ff);
   // pin owned by serial logic when enabled
   assign serial_tx_pin = tx_enable_ff ? tx_line_ff : port_latch_out;
endmodule // usc_uart_status_control

// ===== verification/usc_uart_status_control_asserts.sv
`timescale 1ns/1ps
module usc_uart_status_control_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic rx_char_valid,
   input wire logic port_latch_out,
   input wire logic serial_tx_pin,
   input wire logic irq
);
   logic txen_ff;
   logic nxt_txen;
   logic rxhi_ff;
   logic nxt_rxhi;
   logic [2:0] mask_ff;
   logic [2:0] nxt_mask;
   // Shadow of fields written by software
   always_comb begin
      nxt_txen = txen_ff;
      nxt_rxhi = rxhi_ff;
      nxt_mask = mask_ff;
      if (reg_wr && reg_addr == 4'h0) begin
         nxt_txen = reg_wdata[10];
         nxt_rxhi = reg_wdata[7];
      end
      if (reg_wr && reg_addr == 4'h2) begin
         nxt_mask = reg_wdata[2:0];
      end
   end
   // Shadow registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txen_ff <= 1'b0;
         rxhi_ff <= 1'b0;
         mask_ff <= 3'h0;
      end else begin
         txen_ff <= nxt_txen;
         rxhi_ff <= nxt_rxhi;
         mask_ff <= nxt_mask;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rdata_quiet;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside read slot");
   property p_bit12;
      reg_rdata[12] == 1'b0;
   endproperty
   a_bit12: assert property (p_bit12) else $error("bit 12 reads one");
   property p_unmapped;
      $past(reg_rd) && $past(reg_addr) > 4'h3 |-> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_pin_port;
      !txen_ff && !$past(txen_ff) |-> serial_tx_pin == port_latch_out;
   endproperty
   a_pin_port: assert property (p_pin_port) else $error("pin not from port latch");
   property p_irq_masked;
      mask_ff == 3'h0 && $past(mask_ff) == 3'h0 |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
   property p_rx_irq;
      rx_char_valid && !rxhi_ff && mask_ff[1] |-> ##[1:3] irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("no irq on received char");
   property p_full_empty;
      $past(reg_rd) && $past(reg_addr) == 4'h0 |-> !(reg_rdata[9] && reg_rdata[8]);
   endproperty
   a_full_empty: assert property (p_full_empty) else $error("full and empty together");
   property p_txoff_flags;
      $past(reg_rd) && $past(reg_addr) == 4'h0 && !$past(txen_ff) && !$past(txen_ff, 2) |-> reg_rdata[9:8] == 2'b01;
   endproperty
   a_txoff_flags: assert property (p_txoff_flags) else $error("buffer not reset when disabled");
   c_rx_irq: cover property (rx_char_valid && mask_ff[1]);
   c_irq: cover property ($rose(irq));
   c_tx_off: cover property ($fell(txen_ff));
endmodule // usc_uart_status_control_asserts
bind usc_uart_status_control usc_uart_status_control_asserts usc_uart_status_control_asserts_i (.sys_clk, .rst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_char_valid, .port_latch_out, .serial_tx_pin, .irq);

// ===== verification/usc_remote_xcvr.sv
`timescale 1ns/1ps
module usc_remote_xcvr #(
   parameter int BIT_CYC = 4
) (
   input wire logic sys_clk,
   input wire logic serial_tx_pin,
   output logic [7:0] rx_char,
   output logic rx_char_valid,
   output logic rx_parity_error,
   output logic rx_framing_error,
   output logic [7:0] got_char,
   output int max_low
);
   int low_cnt;
   initial begin
      rx_char = 8'h00;
      rx_char_valid = 1'b0;
      rx_parity_error = 1'b0;
      rx_framing_error = 1'b0;
      got_char = 8'h00;
      max_low = 0;
      low_cnt = 0;
   end
   always @(posedge sys_clk) begin
      if (!serial_tx_pin) begin
         low_cnt++;
      end else begin
         if (low_cnt > max_low) max_low = low_cnt;
         low_cnt = 0;
      end
   end
   always begin
      @(negedge serial_tx_pin);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge sys_clk);
         got_char[i] = serial_tx_pin;
      end
      repeat (BIT_CYC) @(posedge sys_clk);
   end
   // One received character; data is scrambled after the strobe
   task automatic send(input logic [7:0] c);
      @(posedge sys_clk);
      rx_char <= c;
      rx_char_valid <= 1'b1;
      @(posedge sys_clk);
      rx_char_valid <= 1'b0;
      rx_char <= ~c;
   endtask
endmodule // usc_remote_xcvr

// ===== verification/test_uart_status_control.sv
`timescale 1ns/1ps
module test_uart_status_control;
   localparam int BIT = 4; // Baud divider 3
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [7:0] tx_data = 8'h00;
   logic tx_data_valid = 1'b0;
   logic [7:0] rx_char;
   logic rx_char_valid, rx_parity_error, rx_framing_error, serial_tx_pin, irq;
   logic rx_pop = 1'b0;
   logic [7:0] rx_data;
   logic [7:0] got_char;
   logic ir_en = 1'b0;
   logic line_idle = 1'b1;
   logic port_latch_out = 1'b1;
   int max_low;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   always #10 sys_clk = ~sys_clk;
   usc_uart_status_control usc_uart_status_control_i (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .tx_data, .tx_data_valid, .rx_char_valid, .rx_char, .rx_parity_error, .rx_framing_error,
      .rx_line_idle_in(line_idle), .rx_pop, .rx_data, .infrared_encode_enable(ir_en), .port_latch_out,
      .serial_rx_pin(serial_tx_pin), .serial_tx_pin, .irq);
   usc_remote_xcvr #(.BIT_CYC(BIT)) usc_remote_xcvr_i (.sys_clk, .serial_tx_pin, .rx_char, .rx_char_valid,
      .rx_parity_error, .rx_framing_error, .got_char, .max_low);
   // Compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask
   // Consecutive character pushes
   task automatic push(input logic [7:0] c, input int n);
      @(posedge sys_clk);
      tx_data_valid <= 1'b1;
      for (int i = 0; i < n; i++) begin
         tx_data <= c + 8'(i);
         @(posedge sys_clk);
      end
      tx_data_valid <= 1'b0;
   endtask
   task automatic pop(input int n);
      @(posedge sys_clk);
      rx_pop <= 1'b1;
      repeat (n) @(posedge sys_clk);
      rx_pop <= 1'b0;
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Run limit
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("MISMATCH at %0t: cycle limit reached", $time);
         conclude();
      end
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(4'h0, 16'h0110);
      rd(4'h1, 16'h0000);
      rd(4'h3, 16'h001A);
      rd(4'h7, 16'h0000);
      line_idle <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(4'h0, 16'h0100);
      line_idle <= 1'b1;
      wr(4'h0, 16'h94E2);
      rd(4'h0, 16'h85F0);
      $display("test reset and fields done");
      wr(4'h3, 16'h0003);
      wr(4'h2, 16'h0007);
      wr(4'h0, 16'h0400);
      push(8'hA5, 1);
      repeat (3) @(posedge sys_clk);
      rd(4'h0, 16'h0410);
      check({15'h0, irq}, 16'h0001);
      rd(4'h1, 16'h0001);
      repeat (45) @(posedge sys_clk);
      check({8'h00, got_char}, 16'h00A5);
      rd(4'h0, 16'h0510);
      wr(4'h0, 16'h8400);
      push(8'hC3, 3);
      repeat (10) @(posedge sys_clk);
      rd(4'h1, 16'h0000);
      repeat (80) @(posedge sys_clk);
      rd(4'h1, 16'h0001);
      repeat (60) @(posedge sys_clk);
      wr(4'h0, 16'h2400);
      rd(4'h1, 16'h0000);
      push(8'h5A, 1);
      repeat (10) @(posedge sys_clk);
      rd(4'h1, 16'h0000);
      repeat (40) @(posedge sys_clk);
      rd(4'h1, 16'h0001);
      check({8'h00, got_char}, 16'h005A);
      $display("test transmit interrupt modes done");
      wr(4'h0, 16'h0400);
      push(8'hF0, 5);
      rd(4'h0, 16'h0610);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0110);
      port_latch_out <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check({15'h0, serial_tx_pin}, 16'h0000);
      port_latch_out <= 1'b1;
      repeat (50) @(posedge sys_clk);
      wr(4'h0, 16'h0C00);
      push(8'h00, 1);
      repeat (130) @(posedge sys_clk);
      rd(4'h0, 16'h0510);
      rd(4'h1, 16'h0001);
      check(16'(max_low), 16'(13 * BIT));
      $display("test full, abort and break done");
      wr(4'h0, 16'h00C0);
      for (int k = 1; k < 4; k++) usc_remote_xcvr_i.send(8'(17 * k));
      rd(4'h1, 16'h0000);
      usc_remote_xcvr_i.send(8'h44);
      rd(4'h1, 16'h0002);
      usc_remote_xcvr_i.send(8'h55);
      rd(4'h0, 16'h01D3);
      rd(4'h1, 16'h0004);
      wr(4'h0, 16'h00C0);
      rd(4'h0, 16'h01D1);
      pop(2);
      repeat (2) @(posedge sys_clk);
      check({8'h00, rx_data}, 16'h0033);
      wr(4'h0, 16'h0080);
      usc_remote_xcvr_i.send(8'h66);
      rd(4'h1, 16'h0002);
      wr(4'h0, 16'h0040);
      pop(2);
      usc_remote_xcvr_i.send(8'h77);
      rd(4'h1, 16'h0002);
      $display("test receive interrupts and overrun done");
      for (int k = 0; k < 4; k++) begin
         wr(4'h0, {1'b0, k[0], 14'h0400});
         ir_en <= k[1];
         repeat (3) @(posedge sys_clk);
         check({15'h0, serial_tx_pin}, {15'h0, ~(k[0] ^ k[1])});
      end
      $display("test idle polarity done");
      conclude();
   end
endmodule // test_uart_status_control
